// ===== design/pus_power_up_sequencer.sv
// Power-up sequencer: slot timing, power button, host reset, backup rail and register slave
// Operation
// RULE_01 - Each of eleven outputs holds a 5-bit slot code, positions one to thirty-one.
// RULE_02 - A zero slot code keeps that output out of the sequence and disabled.
// RULE_03 - Output enable time is slot code times the selected step period; here slot one comes at the RULE_06 delay and each later slot one step after.
// RULE_04 - Step select 00/01/10/11 gives 500/1000/2000/4000 us spacing.
// RULE_05 - Sequence ends at the highest programmed slot, skipping unused later slots.
// RULE_06 - Turn-on to slot one takes 2.0/2.5/4.0/7.0 ms per step select.
// RULE_07 - Host reset is released 2.0 ms after the last output is enabled.
// RULE_08 - Backup rail turns on 5.0 ms after main supply, 24 ms without coin cell.
// RULE_09 - Button level mode: high turns on, low turns off.
// RULE_10 - Button edge mode: a falling edge starts the power-up sequence.
// RULE_11 - Edge mode: button held low at least 4.0 s turns the device off.
// RULE_12 - Serial-bus target address is configurable from 0x08 to 0x0F.
// RULE_13 - Address bit 3 is fixed at one; bits 2:0 come from configuration.
// RULE_14 - With check bits enabled, single errors are corrected and double errors detected.
// RULE_15 - Host reset released 2.0 to 4.0 ms after last output, asserted only at turn-off.
// RULE_16 - A slot counter advances per step; outputs matching the count enable together.
// RULE_17 - Configuration is latched before the sequence and not sampled mid-sequence.
//
// Chosen here: the Wishbone slave port and the register offsets.
module pus_power_up_sequencer import pus_pkg::*; #(
    parameter int TICK_CYCLES = TICK_CYCLES_DEF
) (
    input  wire logic               CLK_SYS,
    input  wire logic               RST,
    input  wire logic               WB_CYC_I,
    input  wire logic               WB_STB_I,
    input  wire logic               WB_WE_I,
    input  wire logic [ADR_W-1:0]   WB_ADR_I,
    input  wire logic [3:0]         WB_SEL_I,
    input  wire logic [WORD_W-1:0]  WB_DAT_I,
    output logic      [WORD_W-1:0]  WB_DAT_O,
    output logic                    WB_ACK_O,
    input  wire logic               POWER_BUTTON_INPUT,
    input  wire logic               MAIN_SUPPLY_VALID,
    input  wire logic               COIN_CELL_INPUT,
    output logic      [NUM_OUT-1:0] SUPPLY_ENABLE,
    output logic                    BACKUP_SUPPLY_RAIL_EN,
    output logic                    HOST_RESET_OUT_N_O,
    output logic                    HOST_RESET_OUT_N_OE,
    output logic      [6:0]         BUS_TARGET_ADDR
);
    localparam int             TW        = $clog2(TICK_CYCLES);
    localparam logic [TW-1:0]  TICK_LAST = TW'(TICK_CYCLES - 1);

    pus_state_t         state_q;
    pus_state_t         st_d;
    logic [2:0]         sync1_q;
    logic [2:0]         sync2_q;
    logic               btn;
    logic               main_ok;
    logic               coin_ok;
    logic               btn_prev_q;
    logic               main_prev_q;
    logic               main_rise;
    logic [TW-1:0]      tick_cnt_q;
    logic               tick;
    logic [CW-1:0]      wait_q;
    logic [CW-1:0]      wait_target;
    logic               timed;
    logic               hit;
    logic [SLOT_W-1:0]  slot_q;
    logic [SLOT_W-1:0]  slot_nx;
    logic [SLOT_W-1:0]  max_slot;
    logic [NUM_OUT-1:0] match_next;
    logic [NUM_OUT-1:0] en_q;
    logic [SLOT_W-1:0]  lat_slot_q [NUM_OUT];
    logic [1:0]         lat_step_q;
    logic               lat_mode_q;
    logic [2:0]         lat_addr_q;
    logic               turn_on;
    logic               off_req;
    logic [CW-1:0]      lp_q;
    logic               long_hit;
    logic               coin_late_q;
    logic [CW-1:0]      bk_cnt_q;
    logic               rail_q;
    logic               hr_q;
    logic [WORD_W-1:0]  cfg0_q;
    logic [WORD_W-1:0]  cfg1_q;
    logic [CHK_W-1:0]   chk0_q;
    logic [CHK_W-1:0]   chk1_q;
    logic               ecc_en_q;
    logic               sec_q;
    logic               ded_q;
    logic [2*WORD_W-1:0] cfg_all;
    logic               ecc_block;
    logic               ack_q;
    logic [WORD_W-1:0]  dat_q;
    logic               wb_req;
    logic               wb_wr;
    logic [WORD_W-1:0]  wmask;
    logic [WORD_W-1:0]  rd_data;

    pus_ecc_if ecc0_if ();
    pus_ecc_if ecc1_if ();

    pus_secded_dec u_dec0 (.ecc(ecc0_if.dec));
    pus_secded_dec u_dec1 (.ecc(ecc1_if.dec));

    function automatic logic [WORD_W-1:0] byte_mask(input logic [3:0] sel);
        logic [WORD_W-1:0] m;
        m = '0;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{sel[b]}};
        end
        return m;
    endfunction

    function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] old,
                                                input logic [WORD_W-1:0] nw,
                                                input logic [WORD_W-1:0] m);
        return (old & ~m) | (nw & m);
    endfunction

    function automatic logic [SLOT_W-1:0] slot_field(input logic [2*WORD_W-1:0] w,
                                                     input int i);
        int lsb;
        lsb = (i < SLOTS_IN_W0) ? i * SLOT_W : WORD_W + (i - SLOTS_IN_W0) * SLOT_W;
        return w[lsb +: SLOT_W];
    endfunction

    function automatic logic [CW-1:0] step_ticks(input logic [1:0] s);
        return CW'(STEP_US[s] / TICK_US);
    endfunction

    function automatic logic [CW-1:0] pre_ticks(input logic [1:0] s);
        return CW'((FIRST_US[s] - STEP_US[s]) / TICK_US);
    endfunction

    // Pin synchronisers and edge history
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            sync1_q     <= '0;
            sync2_q     <= '0;
            btn_prev_q  <= 1'b0;
            main_prev_q <= 1'b0;
        end else begin
            sync1_q     <= {COIN_CELL_INPUT, MAIN_SUPPLY_VALID, POWER_BUTTON_INPUT};
            sync2_q     <= sync1_q;
            btn_prev_q  <= sync2_q[0];
            main_prev_q <= sync2_q[1];
        end
    end

    assign btn       = sync2_q[0];
    assign main_ok   = sync2_q[1];
    assign coin_ok   = sync2_q[2];
    assign main_rise = main_ok && !main_prev_q;

    // Tick base, restarted at a turn-on so the first slot lands on time
    always_ff @(posedge CLK_SYS) begin
        if (RST || tick || (state_q == ST_OFF && turn_on)) begin
            tick_cnt_q <= '0;
        end else begin
            tick_cnt_q <= tick_cnt_q + 1'b1;
        end
    end

    assign tick = (tick_cnt_q == TICK_LAST);

    // Configuration words, repaired when check bits are enabled
    assign ecc0_if.raw = cfg0_q;
    assign ecc0_if.chk = chk0_q;
    assign ecc1_if.raw = cfg1_q;
    assign ecc1_if.chk = chk1_q;
    assign cfg_all     = ecc_en_q ? {ecc1_if.fixed, ecc0_if.fixed} : {cfg1_q, cfg0_q}; // [RULE_14]
    assign ecc_block   = ecc_en_q && (ecc0_if.ded || ecc1_if.ded);

    // Configuration tracked while off and frozen once a sequence starts
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            for (int i = 0; i < NUM_OUT; i++) begin
                lat_slot_q[i] <= '0;
            end
            lat_step_q <= '0;
            lat_mode_q <= 1'b0;
            lat_addr_q <= '0;
        end else if (state_q == ST_OFF) begin // [RULE_17]
            for (int i = 0; i < NUM_OUT; i++) begin
                lat_slot_q[i] <= slot_field(cfg_all, i); // [RULE_01]
            end
            lat_step_q <= cfg_all[WORD_W + CFG_STEP_LSB +: 2];
            lat_mode_q <= cfg_all[WORD_W + CFG_MODE_BIT];
            lat_addr_q <= cfg_all[WORD_W + CFG_ADDR_LSB +: ADDR_LOW_W]; // [RULE_13]
        end
    end

    // Highest slot in use and outputs due at the next slot
    assign slot_nx = slot_q + 1'b1;

    always_comb begin
        max_slot   = '0;
        match_next = '0;
        for (int i = 0; i < NUM_OUT; i++) begin
            if (lat_slot_q[i] > max_slot) begin
                max_slot = lat_slot_q[i]; // [RULE_05]
            end
            match_next[i] = (lat_slot_q[i] == slot_nx); // [RULE_02] [RULE_16]
        end
    end

    // Turn-on and turn-off requests from the button and the main supply
    assign turn_on  = main_ok && !ecc_block &&
                      (lat_mode_q ? (btn_prev_q && !btn) : btn); // [RULE_09] [RULE_10]
    assign long_hit = (lp_q == LONG_PRESS_TICKS);
    assign off_req  = !main_ok || (lat_mode_q ? long_hit : !btn); // [RULE_09] [RULE_11]

    always_ff @(posedge CLK_SYS) begin
        if (RST || btn || state_q == ST_OFF || !lat_mode_q) begin
            lp_q <= '0;
        end else if (tick && !long_hit) begin
            lp_q <= lp_q + 1'b1; // [RULE_11]
        end
    end

    // Wait target of each timed state
    always_comb begin
        case (state_q)
            ST_PRE:   wait_target = pre_ticks(lat_step_q);  // [RULE_06]
            ST_SEQ:   wait_target = step_ticks(lat_step_q); // [RULE_03] [RULE_04]
            ST_RWAIT: wait_target = HOST_REL_TICKS;         // [RULE_07] [RULE_15]
            default:  wait_target = '0;
        endcase
    end

    assign timed = (state_q == ST_PRE) || (state_q == ST_SEQ) || (state_q == ST_RWAIT);
    assign hit   = timed && tick && (wait_q == wait_target - 1'b1);

    always_comb begin
        st_d = state_q;
        case (state_q)
            ST_OFF: begin
                if (turn_on) begin
                    st_d = ST_PRE;
                end
            end
            ST_PRE: begin
                if (hit) begin
                    st_d = (max_slot == '0) ? ST_RWAIT : ST_SEQ;
                end
            end
            ST_SEQ: begin
                if (hit && slot_nx == max_slot) begin
                    st_d = ST_RWAIT; // [RULE_05]
                end
            end
            ST_RWAIT: begin
                if (hit) begin
                    st_d = ST_ON;
                end
            end
            ST_ON: begin
                st_d = ST_ON;
            end
            default: begin
                st_d = ST_OFF;
            end
        endcase
        if (state_q != ST_OFF && off_req) begin
            st_d = ST_OFF;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            state_q <= ST_OFF;
        end else begin
            state_q <= st_d;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST || st_d != state_q || hit) begin
            wait_q <= '0;
        end else if (timed && tick) begin
            wait_q <= wait_q + 1'b1;
        end
    end

    // Slot counter and supply enables
    always_ff @(posedge CLK_SYS) begin
        if (RST || st_d == ST_OFF || state_q == ST_OFF) begin
            slot_q <= '0;
        end else if (state_q == ST_SEQ && hit) begin
            slot_q <= slot_nx; // [RULE_16]
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST || st_d == ST_OFF) begin
            en_q <= '0;
        end else if (state_q == ST_SEQ && hit) begin
            en_q <= en_q | match_next; // [RULE_03] [RULE_16]
        end
    end

    // Host reset held except in the on state
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            hr_q <= 1'b1;
        end else begin
            hr_q <= (st_d != ST_ON); // [RULE_07] [RULE_15]
        end
    end

    // Backup rail after main supply arrival
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            coin_late_q <= 1'b0;
        end else if (main_rise) begin
            coin_late_q <= !coin_ok;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST || !main_ok || main_rise) begin
            bk_cnt_q <= '0;
        end else if (tick && !rail_q) begin
            bk_cnt_q <= bk_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            rail_q <= 1'b0;
        end else begin
            rail_q <= main_ok && (rail_q || (!main_rise && bk_cnt_q ==
                      (coin_late_q ? BACKUP_LATE_TICKS : BACKUP_TYP_TICKS))); // [RULE_08]
        end
    end

    // Register slave
    assign wb_req = WB_CYC_I && WB_STB_I && !ack_q;
    assign wb_wr  = wb_req && WB_WE_I;
    assign wmask  = byte_mask(WB_SEL_I);

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            cfg0_q <= CFG0_DEF;
            cfg1_q <= CFG1_DEF;
        end else if (wb_wr && WB_ADR_I == REG_CFG0) begin
            cfg0_q <= merge(cfg0_q, WB_DAT_I, wmask); // [RULE_01]
        end else if (wb_wr && WB_ADR_I == REG_CFG1) begin
            cfg1_q <= merge(cfg1_q, WB_DAT_I, wmask); // [RULE_12]
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            chk0_q   <= CHK0_DEF;
            chk1_q   <= CHK1_DEF;
            ecc_en_q <= 1'b0;
        end else if (wb_wr && WB_ADR_I == REG_CHECK) begin
            if (WB_SEL_I[0]) begin
                chk0_q <= WB_DAT_I[CHK_W-1:0];
            end
            if (WB_SEL_I[1]) begin
                chk1_q <= WB_DAT_I[CHK1_LSB +: CHK_W];
            end
        end else if (wb_wr && WB_ADR_I == REG_CTRL && WB_SEL_I[0]) begin
            ecc_en_q <= WB_DAT_I[CTRL_ECC_BIT];
        end
    end

    // Sticky check-bit error flags, a new error wins over a clear
    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            sec_q <= 1'b0;
            ded_q <= 1'b0;
        end else begin
            sec_q <= (sec_q && !(wb_wr && WB_ADR_I == REG_STATUS && wmask[ST_SEC_BIT] &&
                      WB_DAT_I[ST_SEC_BIT])) ||
                     (ecc_en_q && state_q == ST_OFF && (ecc0_if.sec || ecc1_if.sec)); // [RULE_14]
            ded_q <= (ded_q && !(wb_wr && WB_ADR_I == REG_STATUS && wmask[ST_DED_BIT] &&
                      WB_DAT_I[ST_DED_BIT])) ||
                     (ecc_en_q && state_q == ST_OFF && (ecc0_if.ded || ecc1_if.ded)); // [RULE_14]
        end
    end

    always_comb begin
        rd_data = '0;
        case (WB_ADR_I)
            REG_CFG0: rd_data = cfg0_q;
            REG_CFG1: rd_data = cfg1_q;
            REG_CHECK: begin
                rd_data[CHK_W-1:0]          = chk0_q;
                rd_data[CHK1_LSB +: CHK_W]  = chk1_q;
            end
            REG_CTRL: rd_data[CTRL_ECC_BIT] = ecc_en_q;
            REG_STATUS: begin
                rd_data[2:0]                 = state_q;
                rd_data[ST_SLOT_LSB +: SLOT_W] = slot_q;
                rd_data[ST_SEC_BIT]          = sec_q;
                rd_data[ST_DED_BIT]          = ded_q;
            end
            REG_OUTS: begin
                rd_data[NUM_OUT-1:0]         = en_q;
                rd_data[OUT_BK_BIT]          = rail_q;
                rd_data[OUT_RST_BIT]         = hr_q;
                rd_data[OUT_ADDR_LSB +: 7]   = BUS_TARGET_ADDR;
            end
            default: rd_data = '0;
        endcase
    end

    always_ff @(posedge CLK_SYS) begin
        if (RST) begin
            ack_q <= 1'b0;
            dat_q <= '0;
        end else begin
            ack_q <= wb_req;
            dat_q <= (wb_req && !WB_WE_I) ? rd_data : '0;
        end
    end

    assign WB_ACK_O              = ack_q;
    assign WB_DAT_O              = dat_q;
    assign SUPPLY_ENABLE         = en_q;
    assign BACKUP_SUPPLY_RAIL_EN = rail_q;
    assign HOST_RESET_OUT_N_O    = 1'b0;
    assign HOST_RESET_OUT_N_OE   = hr_q;
    assign BUS_TARGET_ADDR       = {TGT_ADDR_HI, lat_addr_q}; // [RULE_12] [RULE_13]
endmodule

// ===== design/pus_pkg.sv
// Shared constants, register map, state codes and check-bit helpers of the power-up sequencer
package pus_pkg;
    // Clock and time base
    localparam int CLK_HZ          = 40_000_000;
    localparam int US_PER_S        = 1_000_000;
    localparam int TICK_US         = 500;
    localparam int TICK_CYCLES_DEF = CLK_HZ / US_PER_S * TICK_US;
    localparam int CW              = 14;

    // Times in microseconds, counted in ticks of TICK_US
    localparam int STEP_US [4]     = '{500, 1000, 2000, 4000};
    localparam int FIRST_US [4]    = '{2000, 2500, 4000, 7000};
    localparam int HOST_REL_US     = 2000;
    localparam int BACKUP_TYP_US   = 5000;
    localparam int BACKUP_LATE_US  = 24000;
    localparam int LONG_PRESS_US   = 4_000_000;

    localparam logic [CW-1:0] HOST_REL_TICKS    = CW'(HOST_REL_US / TICK_US);
    localparam logic [CW-1:0] BACKUP_TYP_TICKS  = CW'(BACKUP_TYP_US / TICK_US);
    localparam logic [CW-1:0] BACKUP_LATE_TICKS = CW'(BACKUP_LATE_US / TICK_US);
    // One extra tick covers the unknown phase of the first tick
    localparam logic [CW-1:0] LONG_PRESS_TICKS  = CW'(LONG_PRESS_US / TICK_US + 1);

    // Configuration word layout
    localparam int NUM_OUT      = 11;
    localparam int SLOT_W       = 5;
    localparam int SLOTS_IN_W0  = 6;
    localparam int WORD_W       = 32;
    localparam int CFG_STEP_LSB = 25;
    localparam int CFG_MODE_BIT = 27;
    localparam int CFG_ADDR_LSB = 28;
    localparam int ADDR_LOW_W   = 3;
    localparam logic [3:0] TGT_ADDR_HI = 4'h1;

    // Default start-up configuration
    localparam logic [WORD_W-1:0] CFG0_DEF = 32'h0031_8C41;
    localparam logic [WORD_W-1:0] CFG1_DEF = 32'h0231_8C02;

    // Register map, byte addresses
    localparam int ADR_W = 8;
    localparam logic [ADR_W-1:0] REG_CFG0   = 8'h00;
    localparam logic [ADR_W-1:0] REG_CFG1   = 8'h04;
    localparam logic [ADR_W-1:0] REG_CHECK  = 8'h08;
    localparam logic [ADR_W-1:0] REG_CTRL   = 8'h0C;
    localparam logic [ADR_W-1:0] REG_STATUS = 8'h10;
    localparam logic [ADR_W-1:0] REG_OUTS   = 8'h14;

    localparam int CHK1_LSB     = 8;
    localparam int CTRL_ECC_BIT = 0;
    localparam int ST_SLOT_LSB  = 8;
    localparam int ST_SEC_BIT   = 16;
    localparam int ST_DED_BIT   = 17;
    localparam int OUT_BK_BIT   = 16;
    localparam int OUT_RST_BIT  = 17;
    localparam int OUT_ADDR_LSB = 24;

    typedef enum logic [2:0] {
        ST_OFF   = 3'b000,
        ST_PRE   = 3'b001,
        ST_SEQ   = 3'b010,
        ST_RWAIT = 3'b011,
        ST_ON    = 3'b100
    } pus_state_t;

    // Single-error-correct, double-error-detect code over one 32-bit word
    localparam int SYN_W        = 6;
    localparam int CHK_W        = 7;
    localparam int ECC_POS_LAST = 38;

    function automatic logic [SYN_W-1:0] pus_ecc_syn(input logic [WORD_W-1:0] d);
        logic [SYN_W-1:0] s;
        int               k;
        s = '0;
        k = 0;
        for (int p = 1; p <= ECC_POS_LAST; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (d[k]) begin
                    s = s ^ p[SYN_W-1:0];
                end
                k++;
            end
        end
        return s;
    endfunction

    function automatic logic [CHK_W-1:0] pus_ecc_check(input logic [WORD_W-1:0] d);
        logic [SYN_W-1:0] s;
        s = pus_ecc_syn(d);
        return {^{d, s}, s};
    endfunction

    localparam logic [CHK_W-1:0] CHK0_DEF = pus_ecc_check(CFG0_DEF);
    localparam logic [CHK_W-1:0] CHK1_DEF = pus_ecc_check(CFG1_DEF);
endpackage

// ===== design/pus_ecc_if.sv
// Carrier between the sequencer and its configuration-word error decoder
interface pus_ecc_if import pus_pkg::*;;
    logic [WORD_W-1:0] raw;
    logic [CHK_W-1:0]  chk;
    logic [WORD_W-1:0] fixed;
    logic              sec;
    logic              ded;
    modport dec (input raw, input chk, output fixed, output sec, output ded);
    modport usr (output raw, output chk, input fixed, input sec, input ded);
endinterface

// ===== design/pus_secded_dec.sv
// Check-bit decoder that repairs one flipped bit and flags two in a configuration word
module pus_secded_dec import pus_pkg::*; (
    pus_ecc_if.dec ecc
);
    logic [SYN_W-1:0] syn;
    logic             ovr;

    function automatic logic [WORD_W-1:0] fix_bit(input logic [WORD_W-1:0] d,
                                                  input logic [SYN_W-1:0] s);
        logic [WORD_W-1:0] r;
        int                k;
        r = d;
        k = 0;
        for (int p = 1; p <= ECC_POS_LAST; p++) begin
            if ((p & (p - 1)) != 0) begin
                if (p[SYN_W-1:0] == s) begin
                    r[k] = ~d[k];
                end
                k++;
            end
        end
        return r;
    endfunction

    always_comb begin
        syn       = pus_ecc_syn(ecc.raw) ^ ecc.chk[SYN_W-1:0];
        ovr       = ^{ecc.raw, ecc.chk};
        ecc.sec   = ovr;                                  // [RULE_14]
        ecc.ded   = !ovr && (syn != '0);                  // [RULE_14]
        ecc.fixed = ovr ? fix_bit(ecc.raw, syn) : ecc.raw; // [RULE_14]
    end
endmodule

// ===== bench/pus_seq_chk.sv
// Port-level assertions for the power-up sequencer
module pus_seq_chk import pus_pkg::*; (
    input wire logic               CLK_SYS,
    input wire logic               RST,
    input wire logic               WB_CYC_I,
    input wire logic               WB_STB_I,
    input wire logic               WB_ACK_O,
    input wire logic               MAIN_SUPPLY_VALID,
    input wire logic [NUM_OUT-1:0] SUPPLY_ENABLE,
    input wire logic               BACKUP_SUPPLY_RAIL_EN,
    input wire logic               HOST_RESET_OUT_N_O,
    input wire logic               HOST_RESET_OUT_N_OE,
    input wire logic [6:0]         BUS_TARGET_ADDR
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (RST);
    property p_ack; WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O; endproperty
    a_ack: assert property (p_ack) else $error("request not acked");
    property p_ack1; WB_ACK_O |=> !WB_ACK_O; endproperty
    a_ack1: assert property (p_ack1) else $error("ack longer than one cycle");
    property p_od; HOST_RESET_OUT_N_O == 1'b0; endproperty
    a_od: assert property (p_od) else $error("reset pin data not low");
    property p_addr; BUS_TARGET_ADDR[6:3] == 4'h1; endproperty
    a_addr: assert property (p_addr) else $error("target address high bits");
    property p_new; |(SUPPLY_ENABLE & ~$past(SUPPLY_ENABLE)) |-> HOST_RESET_OUT_N_OE; endproperty
    a_new: assert property (p_new) else $error("enable after reset release");
    property p_rel; $fell(HOST_RESET_OUT_N_OE) |-> SUPPLY_ENABLE == $past(SUPPLY_ENABLE, 70);
    endproperty
    a_rel: assert property (p_rel) else $error("release too close to enable");
    property p_off; !MAIN_SUPPLY_VALID [*5] |-> SUPPLY_ENABLE == '0 && HOST_RESET_OUT_N_OE;
    endproperty
    a_off: assert property (p_off) else $error("outputs on without supply");
    property p_bk; $rose(BACKUP_SUPPLY_RAIL_EN) |-> $past(MAIN_SUPPLY_VALID, 190); endproperty
    a_bk: assert property (p_bk) else $error("backup rail too early");
    c_rel: cover property ($fell(HOST_RESET_OUT_N_OE));
    c_bk: cover property ($rose(BACKUP_SUPPLY_RAIL_EN));
    c_off: cover property ($fell(|SUPPLY_ENABLE));
endmodule

// ===== bench/pus_far.sv
// Far-side model: pulled-up host reset line and rise times of the enables
module pus_far (
    input wire logic        clk,
    input wire logic [10:0] en,
    input wire logic        oe,
    input wire logic        o,
    input wire logic        clr,
    output logic            rst_n,
    output int              cyc,
    output int              up [11]
);
    timeunit 1ns;
    timeprecision 1ps;
    // Open-drain line: pull-up wins while the device lets go
    assign rst_n = oe ? o : 1'b1;
    initial cyc = 0;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        for (int i = 0; i < 11; i++) begin
            if (clr) up[i] <= -1;
            else if (en[i] && up[i] < 0) up[i] <= cyc;
        end
    end
endmodule

// ===== bench/tb_top.sv
// Self-checking bench for the power-up sequencer
module tb_top import pus_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int T = 20;
    logic        CLK_SYS, RST, req, we, btn, mainv, coin, clr, ack, rail, oe, od, rst_n;
    logic [7:0]  adr;
    logic [31:0] dat, rd, rdat;
    logic [10:0] en;
    logic [6:0]  addr;
    int          error_cnt, n_checks, cyc, up [11];
    pus_power_up_sequencer #(.TICK_CYCLES(T)) u_dut (.CLK_SYS(CLK_SYS), .RST(RST),
        .WB_CYC_I(req), .WB_STB_I(req), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
        .WB_DAT_I(dat), .WB_DAT_O(rd), .WB_ACK_O(ack), .POWER_BUTTON_INPUT(btn),
        .MAIN_SUPPLY_VALID(mainv), .COIN_CELL_INPUT(coin), .SUPPLY_ENABLE(en),
        .BACKUP_SUPPLY_RAIL_EN(rail), .HOST_RESET_OUT_N_O(od), .HOST_RESET_OUT_N_OE(oe),
        .BUS_TARGET_ADDR(addr));
    pus_far u_far (.clk(CLK_SYS), .en(en), .oe(oe), .o(od), .clr(clr), .rst_n(rst_n),
        .cyc(cyc), .up(up));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        req <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge CLK_SYS); while (ack !== 1'b1);
        rdat = rd;
        req <= 1'b0;
    endtask
    task automatic tk(input int n); repeat (n * T) @(posedge CLK_SYS); endtask
    task automatic summarize;
        if (error_cnt == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic t_backup;
        int d;
        for (int k = 0; k < 2; k++) begin
            RST <= 1'b1;
            mainv <= 1'b0;
            coin <= k[0];
            repeat (8) @(posedge CLK_SYS);
            RST <= 1'b0;
            mainv <= 1'b1;
            d = k ? BACKUP_TYP_TICKS : BACKUP_LATE_TICKS;
            tk(d - 1);
            chk(32'(rail), 32'h0);
            tk(2);
            chk(32'(rail), 32'h1);
        end
    endtask
    task automatic t_reset;
        chk(32'({oe, en}), 32'h800);
        chk(32'(addr), 32'h08);
        wb(1'b0, REG_CFG0, 32'h0);
        chk(rdat, CFG0_DEF);
        wb(1'b0, 8'h40, 32'h0);
        chk(rdat, 32'h0);
    endtask
    task automatic t_seq(input int s);
        int st, t0, n, d;
        logic [2:0] a;
        a = 3'(s * 2 + 1);
        st = STEP_US[s] / TICK_US * T;
        wb(1'b1, REG_CFG0, 32'h0401_0001);
        wb(1'b1, REG_CFG1, {1'b0, a, 1'b0, 2'(s), 5'(5 + s), 20'h0});
        clr <= 1'b1;
        @(posedge CLK_SYS);
        clr <= 1'b0;
        btn <= 1'b1;
        t0 = cyc;
        n = 0;
        while (en[0] !== 1'b1 && n++ < 9999) @(posedge CLK_SYS);
        wb(1'b1, REG_CFG1, 32'h0);
        while (rst_n !== 1'b1 && n++ < 9999) @(posedge CLK_SYS);
        d = up[0] - t0 - FIRST_US[s] / TICK_US * T;
        chk(32'(d >= 0 && d <= 5), 32'h1);
        chk(32'(up[3] - up[0]), 32'(st));
        chk(32'(up[5]), 32'(up[3]));
        chk(32'(up[10] - up[0]), 32'((4 + s) * st));
        chk(32'(up[1]), 32'hFFFF_FFFF);
        d = cyc - up[10] - 4 * T;
        chk(32'(d >= -1 && d <= 1), 32'h1);
        chk(32'(addr), {25'h0, 4'h1, a});
        btn <= 1'b0;
        repeat (5) @(posedge CLK_SYS);
        chk(32'({oe, en}), 32'h800);
    endtask
    task automatic t_ecc;
        wb(1'b1, REG_CFG1, CFG1_DEF);
        wb(1'b1, REG_CTRL, 32'h1);
        wb(1'b1, REG_CFG0, CFG0_DEF ^ 32'h1);
        wb(1'b1, REG_STATUS, 32'h3_0000);
        wb(1'b0, REG_STATUS, 32'h0);
        chk(32'(rdat[17:16]), 32'h1);
        wb(1'b1, REG_CFG0, CFG0_DEF ^ 32'h3);
        wb(1'b0, REG_STATUS, 32'h0);
        chk(32'(rdat[17]), 32'h1);
        btn <= 1'b1;
        tk(10);
        chk(32'(en), 32'h0);
        btn <= 1'b0;
        wb(1'b1, REG_CTRL, 32'h0);
    endtask
    task automatic t_edge;
        wb(1'b1, REG_CFG1, 32'h0800_0001);
        btn <= 1'b1;
        tk(10);
        chk(32'(en), 32'h0);
        btn <= 1'b0;
        tk(10);
        chk(32'(en[6]), 32'h1);
        mainv <= 1'b0;
        repeat (6) @(posedge CLK_SYS);
        chk(32'({oe, en}), 32'h800);
    endtask
    initial begin
        CLK_SYS = 1'b0;
        forever #12.5 CLK_SYS = ~CLK_SYS;
    end
    initial begin
        {RST, req, we, btn, mainv, coin, clr, adr, dat} = '0;
        RST = 1'b1;
        error_cnt = 0;
        n_checks = 0;
        t_backup;
        t_reset;
        for (int s = 0; s < 4; s++) t_seq(s);
        t_ecc;
        t_edge;
        summarize;
    end
    initial begin
        repeat (30000) @(posedge CLK_SYS);
        error_cnt++;
        summarize;
    end
endmodule
bind pus_power_up_sequencer pus_seq_chk u_chk (.CLK_SYS, .RST, .WB_CYC_I, .WB_STB_I,
    .WB_ACK_O, .MAIN_SUPPLY_VALID, .SUPPLY_ENABLE, .BACKUP_SUPPLY_RAIL_EN,
    .HOST_RESET_OUT_N_O, .HOST_RESET_OUT_N_OE, .BUS_TARGET_ADDR);
